// [core/led_ctrl_pkg.sv]
// constants, types and register map of the engine mode and output control bank
package led_ctrl_pkg;

  localparam int NUM_OUT = 9;
  localparam int NUM_ENG = 3;
  localparam int PWM_W = 8;

  // register offsets on the serial control port
  localparam logic [7:0] ENGINE_MODE_SELECT_ADDR = 8'h01;
  localparam logic [7:0] RATIO_DIMMING_ENABLE_HIGH_ADDR = 8'h02;
  localparam logic [7:0] RATIO_DIMMING_ENABLE_LOW_ADDR = 8'h03;
  localparam logic [7:0] OUTPUT_SWITCH_HIGH_ADDR = 8'h04;
  localparam logic [7:0] OUTPUT_SWITCH_LOW_ADDR = 8'h05;

  // field positions: engine n mode at [hi:lo], output nine at bit 0 of the high registers
  localparam int FIRST_MODE_LO = 4;
  localparam int SECOND_MODE_LO = 2;
  localparam int THIRD_MODE_LO = 0;
  localparam int OUT9_BIT = 0;

  // reset values
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [8:0] RATIO_RESET = 9'h000;
  localparam logic [8:0] SWITCH_RESET = 9'h000;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // step control code that keeps an engine on hold
  localparam logic [1:0] STEP_HOLD = 2'h0;

  typedef enum logic [1:0] {
    MODE_DISABLED,
    MODE_LOAD,
    MODE_RUN,
    MODE_HALT
  } engine_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [1:0] exec;
    logic run;
    logic halt;
    logic disabled;
    logic load;
  } engine_ctrl_t;

endpackage

// [core/ratio_scaler.sv]
// one output's pwm path: ratiometric scaling and freeze while a program loads
`timescale 1ns/100ps
module ratio_scaler #(
  parameter int W = 8
) (
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic freeze_in, // hold the present pwm value
  input wire logic ratio_en_in, // ratiometric dimming on
  input wire logic [W-1:0] pwm_in, // set pwm level
  input wire logic [W:0] level_in, // group level, 2**W is unity
  output logic [W-1:0] pwm_out // final pwm level
);

  logic [2*W:0] prod;
  logic [W:0] scaled;
  logic [W-1:0] pwm_nxt;

  if (W < 4 || W > 12)
  begin : g_bad_width
    $error("ratio_scaler: W must lie in 4..12");
  end

  // product over unity keeps channel ratios, so colour holds while dimming
  always_comb
  begin
    prod = pwm_in * level_in;
    scaled = prod[2*W:W];
    if (!ratio_en_in)
      pwm_nxt = pwm_in;
    else if (scaled[W])
      pwm_nxt = {W{1'h1}};
    else
      pwm_nxt = scaled[W-1:0];
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pwm_out <= '0;
    else if (!freeze_in)
      pwm_out <= pwm_nxt;
  end

endmodule

// [core/led_engine_mode_output_ctrl.sv]
// engine mode, ratiometric enable and output switch register bank
`timescale 1ns/100ps
module led_engine_mode_output_ctrl (
  input wire logic clk_in, // 200 MHz system clock
  input wire logic rst_n_in, // async reset, active low
  input wire led_ctrl_pkg::reg_req_t req_in, // register request from the serial port
  output logic [7:0] rdata_out, // read data, valid the cycle after rd
  input wire logic [1:0] first_engine_step_control_in, // step control, first engine
  input wire logic [1:0] second_engine_step_control_in, // step control, second engine
  input wire logic [1:0] third_engine_step_control_in, // step control, third engine
  output led_ctrl_pkg::engine_ctrl_t [2:0] engine_out, // per-engine control, index 2 is first
  output logic [2:0] pc_clear_out, // one-cycle program counter clear
  input wire logic [8:0] engine_select_in, // engine has taken this output
  input wire logic [8:0] engine_on_in, // engine's on state for the output
  input wire logic [8:0][7:0] pwm_in, // set pwm per output
  input wire logic [8:0] level_in, // ratiometric group level, 256 is unity
  output logic [8:0][7:0] pwm_out, // final pwm per output
  output logic [8:0] out_on_out // current source enable per output
);
  import led_ctrl_pkg::*;

  engine_mode_t [2:0] mode_r;
  engine_mode_t [2:0] mode_nxt;
  logic [2:0] pc_clear_r;
  logic [2:0] pc_clear_nxt;
  logic [8:0] ratio_r;
  logic [8:0] switch_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [2:0][1:0] step;
  engine_ctrl_t [2:0] eng_r;
  logic [8:0] on_r;
  logic any_load;

  assign step[2] = first_engine_step_control_in;
  assign step[1] = second_engine_step_control_in;
  assign step[0] = third_engine_step_control_in;

  // load is taken only from disabled (or repeated while loading)
  function automatic engine_mode_t accept_mode(input engine_mode_t cur, input logic [1:0] req);
    engine_mode_t want;
    want = engine_mode_t'(req);
    if (want == MODE_LOAD && cur != MODE_DISABLED && cur != MODE_LOAD)
      return cur;
    return want;
  endfunction

  function automatic logic hit(input reg_req_t r, input logic [7:0] a);
    return r.addr == a;
  endfunction

  // mode writes; each field lands on its own engine
  always_comb
  begin
    mode_nxt = mode_r;
    pc_clear_nxt = 3'h0;
    if (req_in.wr && hit(req_in, ENGINE_MODE_SELECT_ADDR))
    begin
      mode_nxt[2] = accept_mode(mode_r[2], req_in.wdata[FIRST_MODE_LO +: 2]);
      mode_nxt[1] = accept_mode(mode_r[1], req_in.wdata[SECOND_MODE_LO +: 2]);
      mode_nxt[0] = accept_mode(mode_r[0], req_in.wdata[THIRD_MODE_LO +: 2]);
      for (int i = 0; i < NUM_ENG; i++)
        pc_clear_nxt[i] = (mode_nxt[i] == MODE_LOAD);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mode_r <= '{engine_mode_t'(MODE_RESET), engine_mode_t'(MODE_RESET), engine_mode_t'(MODE_RESET)};
      pc_clear_r <= 3'h0;
    end
    else
    begin
      mode_r <= mode_nxt;
      pc_clear_r <= pc_clear_nxt;
    end
  end

  // ratiometric enables and software switches
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ratio_r <= RATIO_RESET;
      switch_r <= SWITCH_RESET;
    end
    else if (req_in.wr)
    begin
      if (hit(req_in, RATIO_DIMMING_ENABLE_HIGH_ADDR))
        ratio_r[8] <= req_in.wdata[OUT9_BIT];
      if (hit(req_in, RATIO_DIMMING_ENABLE_LOW_ADDR))
        ratio_r[7:0] <= req_in.wdata;
      if (hit(req_in, OUTPUT_SWITCH_HIGH_ADDR))
        switch_r[8] <= req_in.wdata[OUT9_BIT];
      if (hit(req_in, OUTPUT_SWITCH_LOW_ADDR))
        switch_r[7:0] <= req_in.wdata;
    end
  end

  // read mux; unmapped offsets and unused bits read zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    case (req_in.addr)
      ENGINE_MODE_SELECT_ADDR: rdata_nxt = {2'h0, mode_r[2], mode_r[1], mode_r[0]};
      RATIO_DIMMING_ENABLE_HIGH_ADDR: rdata_nxt = {7'h00, ratio_r[8]};
      RATIO_DIMMING_ENABLE_LOW_ADDR: rdata_nxt = ratio_r[7:0];
      OUTPUT_SWITCH_HIGH_ADDR: rdata_nxt = {7'h00, switch_r[8]};
      OUTPUT_SWITCH_LOW_ADDR: rdata_nxt = switch_r[7:0];
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_r <= RDATA_RESET;
    else if (req_in.rd)
      rdata_r <= rdata_nxt;
  end

  assign any_load = (mode_r[0] == MODE_LOAD) || (mode_r[1] == MODE_LOAD) || (mode_r[2] == MODE_LOAD);

  // engine control, one cycle behind the mode field
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      eng_r <= '0;
    else
      for (int i = 0; i < NUM_ENG; i++)
      begin
        eng_r[i].run <= (mode_r[i] == MODE_RUN) && !any_load;
        eng_r[i].exec <= ((mode_r[i] == MODE_RUN) && !any_load) ? step[i] : STEP_HOLD;
        eng_r[i].halt <= (mode_r[i] == MODE_HALT);
        eng_r[i].disabled <= (mode_r[i] == MODE_DISABLED);
        eng_r[i].load <= (mode_r[i] == MODE_LOAD);
      end
  end

  // engine selection wins over the software switch
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      on_r <= 9'h000;
    else
      for (int k = 0; k < NUM_OUT; k++)
        on_r[k] <= engine_select_in[k] ? engine_on_in[k] : switch_r[k];
  end

  for (genvar g = 0; g < NUM_OUT; g++)
  begin : g_pwm
    ratio_scaler #(
      .W(PWM_W)
    ) u_scaler (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .freeze_in(any_load),
      .ratio_en_in(ratio_r[g]),
      .pwm_in(pwm_in[g]),
      .level_in({level_in[8], level_in[7:0]}),
      .pwm_out(pwm_out[g])
    );
  end

  assign rdata_out = rdata_r;
  assign engine_out = eng_r;
  assign pc_clear_out = pc_clear_r;
  assign out_on_out = on_r;

  // checks
  sequence s_first_load_req;
    req_in.wr && req_in.addr == ENGINE_MODE_SELECT_ADDR && req_in.wdata[5:4] == 2'h1;
  endsequence

  property p_load_from_run_refused;
    @(posedge clk_in) disable iff (!rst_n_in)
    (mode_r[2] == MODE_RUN) and s_first_load_req |=> mode_r[2] == MODE_RUN;
  endproperty
  a_load_from_run_refused: assert property (p_load_from_run_refused) else $error("load taken from run");

  property p_load_clears_pc;
    @(posedge clk_in) disable iff (!rst_n_in)
    (mode_r[2] == MODE_DISABLED) and s_first_load_req |=> pc_clear_out[2] ##1 !pc_clear_out[2];
  endproperty
  a_load_clears_pc: assert property (p_load_clears_pc) else $error("no single counter clear pulse");

  property p_load_holds_all;
    @(posedge clk_in) disable iff (!rst_n_in)
    any_load |=> !engine_out[0].run && !engine_out[1].run && !engine_out[2].run;
  endproperty
  a_load_holds_all: assert property (p_load_holds_all) else $error("engine ran during load");

  property p_pwm_frozen;
    @(posedge clk_in) disable iff (!rst_n_in)
    any_load ##1 any_load |-> $stable(pwm_out);
  endproperty
  a_pwm_frozen: assert property (p_pwm_frozen) else $error("pwm moved during load");

  property p_run_follows_step;
    @(posedge clk_in) disable iff (!rst_n_in)
    (mode_r[1] == MODE_RUN) && !any_load |=> engine_out[1].exec == $past(step[1]);
  endproperty
  a_run_follows_step: assert property (p_run_follows_step) else $error("step control not passed");

  property p_halt;
    @(posedge clk_in) disable iff (!rst_n_in)
    mode_r[0] == MODE_HALT |=> engine_out[0].halt && !engine_out[0].run && engine_out[0].exec == 2'h0;
  endproperty
  a_halt: assert property (p_halt) else $error("halted engine not stopped");

  property p_override;
    @(posedge clk_in) disable iff (!rst_n_in)
    engine_select_in[3] |=> out_on_out[3] == $past(engine_on_in[3]);
  endproperty
  a_override: assert property (p_override) else $error("switch beat engine");

  property p_unmapped_zero;
    @(posedge clk_in) disable iff (!rst_n_in)
    req_in.rd && (req_in.addr > 8'h05 || req_in.addr == 8'h00) |=> rdata_out == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_switch_readback;
    @(posedge clk_in) disable iff (!rst_n_in)
    req_in.wr && req_in.addr == OUTPUT_SWITCH_HIGH_ADDR ##1 req_in.rd && req_in.addr == OUTPUT_SWITCH_HIGH_ADDR
      && !req_in.wr |=> rdata_out == {7'h00, $past(req_in.wdata[0], 2)};
  endproperty
  a_switch_readback: assert property (p_switch_readback) else $error("switch high readback wrong");

endmodule

// [tb/led_engine_mode_output_ctrl_tb_top.sv]
// self-checking bench for the engine mode and output control bank
`timescale 1ns/100ps
module led_engine_mode_output_ctrl_tb_top;
  import led_ctrl_pkg::*;
  logic clk_in;
  logic rst_n_in;
  reg_req_t req_in;
  logic [7:0] rdata_out;
  logic [1:0] step1, step2, step3;
  engine_ctrl_t [2:0] engine_out;
  logic [2:0] pc_clear_out;
  logic [8:0] engine_select_in, engine_on_in, level_in, out_on_out;
  logic [8:0][7:0] pwm_in, pwm_out;
  int n_mismatch, tests_run, cycles, pc_first, pc_other, b1, b2;
  logic [7:0] ta[4] = '{8'h02, 8'h03, 8'h04, 8'h05};
  logic [7:0] td[4] = '{8'hFF, 8'hA5, 8'hFF, 8'h5A};
  logic [7:0] te[4] = '{8'h01, 8'hA5, 8'h01, 8'h5A};
  logic [8:0] lv[2] = '{9'h080, 9'h100};
  led_engine_mode_output_ctrl dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req_in),
    .rdata_out(rdata_out), .first_engine_step_control_in(step1), .second_engine_step_control_in(step2),
    .third_engine_step_control_in(step3), .engine_out(engine_out), .pc_clear_out(pc_clear_out),
    .engine_select_in(engine_select_in), .engine_on_in(engine_on_in), .pwm_in(pwm_in),
    .level_in(level_in), .pwm_out(pwm_out), .out_on_out(out_on_out));
  always #2.5 clk_in = ~clk_in;
  // pulse counters and hang guard
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (pc_clear_out[2] === 1'h1) pc_first <= pc_first + 1;
    if (pc_clear_out[1:0] !== 2'h0) pc_other <= pc_other + 1;
    if (cycles == 4000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    begin
      tests_run++;
      if (got !== exp)
      begin
        n_mismatch++;
        $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    begin
      @(posedge clk_in);
      req_in <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
      @(posedge clk_in);
      req_in <= '{wr: 1'h0, rd: 1'h0, addr: a, wdata: d};
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    begin
      @(posedge clk_in);
      req_in <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
      @(posedge clk_in);
      req_in <= '{wr: 1'h0, rd: 1'h0, addr: a, wdata: 8'h00};
      @(posedge clk_in);
      #1;
      chk(rdata_out, exp, "read back");
    end
  endtask
  task automatic settle();
    begin
      repeat (3) @(posedge clk_in);
      #1;
    end
  endtask
  task automatic wrap_up();
    begin
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial
  begin
    clk_in = 1'h0;
    rst_n_in = 1'h0;
    req_in = '0;
    step1 = 2'h2;
    step2 = 2'h1;
    step3 = 2'h3;
    engine_select_in = 9'h000;
    engine_on_in = 9'h000;
    pwm_in = {9{8'h28}};
    level_in = 9'h100;
    n_mismatch = 0;
    tests_run = 0;
    cycles = 0;
    pc_first = 0;
    pc_other = 0;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'h1;
    settle();
    for (int a = 1; a <= 5; a++) rd(8'(a), 8'h00);
    for (int i = 0; i < 3; i++) chk(engine_out[i], 6'h02, "engine idle");
    chk(out_on_out, 9'h000, "outputs off after reset");
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h3F);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr(ta[i], td[i]);
      rd(ta[i], te[i]);
    end
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    settle();
    chk(out_on_out, 9'h15A, "software switches");
    rd(8'h04, 8'h01);
    // write then read on consecutive edges
    @(posedge clk_in);
    req_in <= '{wr: 1'h1, rd: 1'h0, addr: 8'h04, wdata: 8'hFE};
    @(posedge clk_in);
    req_in <= '{wr: 1'h0, rd: 1'h1, addr: 8'h04, wdata: 8'h00};
    @(posedge clk_in);
    req_in <= '{wr: 1'h0, rd: 1'h0, addr: 8'h04, wdata: 8'h00};
    @(posedge clk_in);
    #1;
    chk(rdata_out, 8'h00, "back to back readback");
    chk(out_on_out, 9'h05A, "output nine off");
    @(posedge clk_in);
    engine_select_in <= 9'h1FF;
    engine_on_in <= 9'h0A5;
    settle();
    chk(out_on_out, 9'h0A5, "engine overrides switch");
    @(posedge clk_in);
    engine_select_in <= 9'h000;
    // ratio enables are 1A5: scaled outputs halve at level 128
    for (int l = 0; l < 2; l++)
    begin
      @(posedge clk_in);
      level_in <= lv[l];
      settle();
      for (int k = 0; k < 9; k++) chk(pwm_out[k], (9'h1A5 >> k) & 1 ? 8'((40 * lv[l]) >> 8) : 8'h28, "pwm");
    end
    wr(8'h01, 8'h2A);
    settle();
    chk({engine_out[2], engine_out[1], engine_out[0]}, {6'h28, 6'h18, 6'h38}, "run");
    b1 = pc_first;
    wr(8'h01, 8'h1A);
    rd(8'h01, 8'h2A);
    chk(pc_first - b1, 0, "no clear from run");
    wr(8'h01, 8'h3A);
    settle();
    chk(engine_out[2], 6'h04, "halt");
    wr(8'h01, 8'h0A);
    settle();
    chk({engine_out[2], engine_out[1].run, engine_out[0].run}, {6'h02, 2'h3}, "disable one");
    b1 = pc_first;
    b2 = pc_other;
    wr(8'h01, 8'h1A);
    settle();
    chk(pc_first - b1, 1, "clear pulse");
    chk(pc_other - b2, 0, "no stray clear");
    chk({engine_out[2].load, engine_out[1].run, engine_out[0].run}, 3'h4, "load holds all");
    @(posedge clk_in);
    pwm_in <= {9{8'h60}};
    settle();
    chk(pwm_out[0], 8'h28, "pwm frozen");
    wr(8'h01, 8'h2A);
    settle();
    rd(8'h01, 8'h2A);
    chk({engine_out[2].run, pwm_out[0]}, {1'h1, 8'h60}, "resume");
    // level above unity saturates a scaled output
    @(posedge clk_in);
    pwm_in <= {9{8'hFF}};
    level_in <= 9'h1FF;
    settle();
    chk(pwm_out[0], 8'hFF, "saturated scale");
    // reset in mid-run clears every field again
    @(posedge clk_in);
    rst_n_in <= 1'h0;
    repeat (2) @(posedge clk_in);
    #1;
    chk({engine_out[2], out_on_out}, {6'h00, 9'h000}, "outputs low in reset");
    @(posedge clk_in);
    rst_n_in <= 1'h1;
    settle();
    for (int a = 1; a <= 5; a++) rd(8'(a), 8'h00);
    chk(engine_out[2], 6'h02, "disabled after reset");
    wrap_up();
  end
endmodule
